//--- hw/mtd_mac_ctrl.sv
// mac transmit/receive enable, back-off truncation and excessive-deferral abort, with apb registers
// assumes carrier sense and receive bytes arrive from the phy asynchronously; tx bytes leave on the same clock
`timescale 1ns/1ps

module mtd_mac_ctrl
  import mtd_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // transmit buffer side
  input wire logic tx_frame_ready,
  input wire logic [7:0] tx_in_data,
  input wire logic tx_in_valid,
  input wire logic tx_in_last,
  output logic tx_in_ready,
  input wire logic tx_collision,
  // line side transmit
  output logic [7:0] tx_line_data,
  output logic tx_line_valid,
  output logic tx_line_last,
  input wire logic tx_line_ready,
  output logic tx_abort,
  // phy status and receive
  input wire logic phy_crs,
  input wire logic [7:0] phy_rx_data,
  input wire logic phy_rx_valid,
  // receive buffer side
  output logic [7:0] rx_out_data,
  output logic rx_out_valid,
  input wire logic rx_out_ready,
  output logic rx_overrun
);
  import mtd_pkg::*;

  logic [31:0] ctrl_r;
  logic defer_abort_r;
  mtd_tx_e state_r;
  logic [14:0] defer_cnt_r;
  logic [9:0] slots_r;
  logic [8:0] slot_div_r;
  logic [15:0] lfsr_r;
  logic [1:0] crs_sync_r;
  logic [1:0] rxv_sync_r;
  logic [7:0] rxd_s1_r;
  logic [7:0] rxd_s2_r;
  logic rx_prev_r;
  logic bit_tick;
  logic transmit_enable;
  logic receive_enable;
  logic deferral_check_enable;
  logic [3:0] backoff_limit;
  logic crs;
  logic apb_acc;
  logic addr_ok;
  logic rx_push;
  logic rx_buf_ready;
  logic [7:0] sk_data;
  logic sk_valid;
  logic sk_ready;
  logic [7:0] rx_q_data;
  logic rx_q_valid;

  // random value truncated by the back-off limit to 8, 4 or 1 bits; limit 10 also keeps only 4 bits
  function automatic logic [9:0] backoff_mask(input logic [3:0] lim, input logic [15:0] rnd);
    logic [9:0] m;
    m = 10'h3ff;
    case (lim)
      BACKOFF_LIMIT_10: m = 10'h00f;
      BACKOFF_LIMIT_8: m = 10'h0ff;
      BACKOFF_LIMIT_4: m = 10'h00f;
      BACKOFF_LIMIT_1: m = 10'h001;
      default: m = 10'h00f;
    endcase
    return rnd[9:0] & m;
  endfunction

  assign transmit_enable = ctrl_r[CTRL_TRANSMIT_ENABLE_BIT];
  assign receive_enable = ctrl_r[CTRL_RECEIVE_ENABLE_BIT];
  assign deferral_check_enable = ctrl_r[CTRL_DEFERRAL_CHECK_ENABLE_BIT];
  assign backoff_limit = {2'b00, ctrl_r[CTRL_BACKOFF_LIMIT_LSB +: 2]};
  assign crs = crs_sync_r[1];
  assign apb_acc = psel && penable && pready;
  assign addr_ok = (paddr == CTRL_OFFSET) || (paddr == STAT_OFFSET);

  mtd_bit_tick u_tick
  (
    .clock(clock),
    .rst_n(rst_n),
    .bit_tick(bit_tick)
  );

  // apb: one wait state, answer in the access cycle's second edge
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !addr_ok;
      if (psel && penable && !pready && !pwrite)
      begin
        if (paddr == CTRL_OFFSET)
          prdata <= ctrl_r;
        else if (paddr == STAT_OFFSET)
          prdata <= {1'b0, defer_cnt_r, 13'h0000, (state_r == MTD_BACKOFF), (state_r != MTD_IDLE), defer_abort_r};
        else
          prdata <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      ctrl_r <= CTRL_RESET;
    else if (apb_acc && pwrite && paddr == CTRL_OFFSET)
      ctrl_r <= pwdata & 32'h0000_00ec;
  end

  // sticky abort flag, set wins over write-one-to-clear
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      defer_abort_r <= 1'b0;
    else if (state_r == MTD_DEFER && bit_tick && deferral_check_enable && defer_cnt_r >= 15'(DEFER_LIMIT_BITS))
      defer_abort_r <= 1'b1;
    else if (apb_acc && pwrite && paddr == STAT_OFFSET && pwdata[STAT_DEFER_ABORT_BIT])
      defer_abort_r <= 1'b0;
  end

  // synchronisers for phy inputs
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      crs_sync_r <= 2'b00;
      rxv_sync_r <= 2'b00;
      rxd_s1_r <= 8'h00;
      rxd_s2_r <= 8'h00;
      rx_prev_r <= 1'b0;
    end
    else
    begin
      crs_sync_r <= {crs_sync_r[0], phy_crs};
      rxv_sync_r <= {rxv_sync_r[0], phy_rx_valid};
      rxd_s1_r <= phy_rx_data;
      rxd_s2_r <= rxd_s1_r;
      rx_prev_r <= rxv_sync_r[1];
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      lfsr_r <= 16'hace1;
    else
      lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
  end

  // transmit sequencer
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_r <= MTD_IDLE;
      defer_cnt_r <= 15'h0000;
      slots_r <= 10'h000;
      slot_div_r <= 9'h000;
    end
    else
    begin
      case (state_r)
        MTD_IDLE:
        begin
          defer_cnt_r <= 15'h0000;
          if (transmit_enable && tx_frame_ready)
            state_r <= crs ? MTD_DEFER : MTD_SEND;
        end
        MTD_DEFER:
        begin
          if (!transmit_enable)
            state_r <= MTD_IDLE;
          else if (!crs)
            state_r <= MTD_SEND;
          else if (bit_tick)
          begin
            if (deferral_check_enable && defer_cnt_r >= 15'(DEFER_LIMIT_BITS))
              state_r <= MTD_ABORT;
            else if (defer_cnt_r != 15'h7fff)
              defer_cnt_r <= defer_cnt_r + 15'h0001;
          end
        end
        MTD_SEND:
        begin
          if (tx_collision)
          begin
            state_r <= MTD_BACKOFF;
            slots_r <= backoff_mask(backoff_limit, lfsr_r);
            slot_div_r <= SLOT_BITS_M1;
          end
          else if (tx_line_valid && tx_line_ready && tx_line_last)
            state_r <= MTD_IDLE;
        end
        MTD_BACKOFF:
        begin
          defer_cnt_r <= 15'h0000;
          if (slots_r == 10'h000)
            state_r <= MTD_IDLE;
          else if (bit_tick)
          begin
            // one divider step per bit time, reload after a full slot
            if (slot_div_r == 9'h000)
            begin
              slot_div_r <= SLOT_BITS_M1;
              slots_r <= slots_r - 10'h001;
            end
            else
              slot_div_r <= slot_div_r - 9'h001;
          end
        end
        MTD_ABORT:
          state_r <= MTD_IDLE;
        default:
          state_r <= MTD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      tx_abort <= 1'b0;
    else
      tx_abort <= (state_r == MTD_ABORT);
  end

  // transmit data path through two-entry buffer, gated by sending state
  mtd_skid u_tx_buf
  (
    .clock(clock),
    .rst_n(rst_n),
    .in_data(tx_in_data),
    .in_valid(tx_in_valid && state_r == MTD_SEND && transmit_enable),
    .in_ready(sk_ready),
    .out_data(sk_data),
    .out_valid(sk_valid),
    .out_ready(!tx_line_valid || tx_line_ready)
  );

  assign tx_in_ready = sk_ready && state_r == MTD_SEND && transmit_enable;

  logic last_q_r;
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      last_q_r <= 1'b0;
    else if (tx_in_valid && tx_in_ready)
      last_q_r <= tx_in_last;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      tx_line_data <= 8'h00;
      tx_line_valid <= 1'b0;
      tx_line_last <= 1'b0;
    end
    else if (!tx_line_valid || tx_line_ready)
    begin
      tx_line_data <= sk_data;
      tx_line_valid <= sk_valid;
      tx_line_last <= sk_valid && last_q_r;
    end
  end

  // receive path: one byte per rising edge of synchronised valid
  assign rx_push = rxv_sync_r[1] && !rx_prev_r && receive_enable;

  mtd_skid u_rx_buf
  (
    .clock(clock),
    .rst_n(rst_n),
    .in_data(rxd_s2_r),
    .in_valid(rx_push),
    .in_ready(rx_buf_ready),
    .out_data(rx_q_data),
    .out_valid(rx_q_valid),
    .out_ready(!rx_out_valid || rx_out_ready)
  );

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      rx_out_data <= 8'h00;
      rx_out_valid <= 1'b0;
      rx_overrun <= 1'b0;
    end
    else
    begin
      rx_overrun <= rx_push && !rx_buf_ready;
      if (!rx_out_valid || rx_out_ready)
      begin
        rx_out_data <= rx_q_data;
        rx_out_valid <= rx_q_valid;
      end
    end
  end

  // checks
  sequence s_defer_long;
    state_r == MTD_DEFER && deferral_check_enable && bit_tick && transmit_enable && crs && defer_cnt_r >= 15'(DEFER_LIMIT_BITS);
  endsequence
  sequence s_abort_pulse;
    state_r == MTD_ABORT ##1 tx_abort;
  endsequence

  a_defer_abort_taken: assert property (@(posedge clock) disable iff (!rst_n)
    s_defer_long |=> s_abort_pulse) else $error("deferral limit did not abort");

  a_defer_count_hold: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == MTD_DEFER && !bit_tick |=> defer_cnt_r == $past(defer_cnt_r)) else $error("deferral timer moved off tick");

  a_defer_reset_idle: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == MTD_BACKOFF ##1 state_r == MTD_IDLE |=> defer_cnt_r == 15'h0000) else $error("deferral timer kept value");

  a_no_limit_off: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == MTD_DEFER && !deferral_check_enable |=> state_r != MTD_ABORT) else $error("abort without deferral check");

  a_backoff_trunc: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == MTD_SEND && tx_collision && backoff_limit == BACKOFF_LIMIT_10 |=> slots_r < 10'h010) else $error("slot count too wide");

  a_slot_step: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == MTD_BACKOFF && $past(state_r) == MTD_BACKOFF && slots_r != $past(slots_r) |-> $past(slot_div_r) == 9'h000)
    else $error("slot ended early");

  a_tx_disabled: assert property (@(posedge clock) disable iff (!rst_n)
    !transmit_enable |-> !tx_in_ready) else $error("transmit data taken while disabled");

  a_rx_disabled: assert property (@(posedge clock) disable iff (!rst_n)
    !receive_enable && !rx_q_valid && !rx_out_valid |=> !rx_out_valid) else $error("receive data while disabled");

  a_rx_enabled: assert property (@(posedge clock) disable iff (!rst_n)
    rx_push && rx_buf_ready |=> rx_q_valid) else $error("received byte lost");
endmodule

//--- hw/mtd_pkg.sv
// constants for the mac transmit/receive enable and deferral control block
// assumes a 20 mhz clock and a 10 mbit/s line, one bit time per two clocks
package mtd_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned BIT_RATE_HZ = 10000000;
  localparam int unsigned CLKS_PER_BIT = CLK_HZ / BIT_RATE_HZ;
  localparam int unsigned DEFER_LIMIT_BITS = 24288;
  localparam int unsigned SLOT_BITS = 512;
  localparam logic [8:0] SLOT_BITS_M1 = 9'(SLOT_BITS - 1);
  localparam logic [3:0] BACKOFF_LIMIT_10 = 4'h0;
  localparam logic [3:0] BACKOFF_LIMIT_8 = 4'h1;
  localparam logic [3:0] BACKOFF_LIMIT_4 = 4'h2;
  localparam logic [3:0] BACKOFF_LIMIT_1 = 4'h3;
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] STAT_OFFSET = 12'h004;
  localparam int unsigned CTRL_TRANSMIT_ENABLE_BIT = 3;
  localparam int unsigned CTRL_RECEIVE_ENABLE_BIT = 2;
  localparam int unsigned CTRL_DEFERRAL_CHECK_ENABLE_BIT = 5;
  localparam int unsigned CTRL_BACKOFF_LIMIT_LSB = 6;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int unsigned STAT_DEFER_ABORT_BIT = 0;
  localparam int unsigned STAT_TX_BUSY_BIT = 1;
  localparam int unsigned STAT_BACKOFF_BIT = 2;
  localparam int unsigned STAT_DEFER_CNT_LSB = 16;
  typedef enum logic [2:0] {MTD_IDLE, MTD_DEFER, MTD_SEND, MTD_BACKOFF, MTD_ABORT} mtd_tx_e;
endpackage

//--- hw/mtd_skid.sv
// two-entry buffer with valid/ready on both sides
// assumes one clock, synchronous active-low reset
`timescale 1ns/1ps
module mtd_skid
  import mtd_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // fill side
  input wire logic [7:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // drain side
  output logic [7:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  logic [7:0] mem_r [2];
  logic wp_r;
  logic rp_r;
  logic [1:0] cnt_r;
  logic push;
  logic pop;

  assign in_ready = (cnt_r != 2'd2);
  assign out_valid = (cnt_r != 2'd0);
  assign out_data = mem_r[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem_r[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'd0;
    end
    else
    begin
      if (push)
        wp_r <= ~wp_r;
      if (pop)
        rp_r <= ~rp_r;
      cnt_r <= cnt_r + 2'(push) - 2'(pop);
    end
  end
endmodule

//--- hw/mtd_bit_tick.sv
// bit-time enable pulse divider
// assumes the clock rate is a whole multiple of the bit rate
`timescale 1ns/1ps
module mtd_bit_tick
  import mtd_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // one-cycle pulse per bit time
  output logic bit_tick
);
  logic [3:0] div_r;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      div_r <= 4'h0;
      bit_tick <= 1'b0;
    end
    else if (div_r == 4'(CLKS_PER_BIT - 1))
    begin
      div_r <= 4'h0;
      bit_tick <= 1'b1;
    end
    else
    begin
      div_r <= div_r + 4'h1;
      bit_tick <= 1'b0;
    end
  end
endmodule

//--- testbench/mtd_phy_model.sv
// phy model: carrier sense, receive byte source, transmit byte sink
// assumes the bench drives crs_on and stall just after rising edges
`timescale 1ns/1ps
module mtd_phy_model
(
  // clock
  input wire logic clock,
  // bench controls
  input wire logic crs_on,
  input wire logic stall,
  // phy to mac
  output logic phy_crs,
  output logic [7:0] phy_rx_data,
  output logic phy_rx_valid,
  // mac to line
  input wire logic [7:0] tx_line_data,
  input wire logic tx_line_valid,
  input wire logic tx_line_last,
  output logic tx_line_ready
);
  logic [7:0] tx_got[$];
  logic last_got[$];
  initial
  begin
    phy_rx_data = 8'h00;
    phy_rx_valid = 1'b0;
    tx_line_ready = 1'b1;
  end
  assign phy_crs = crs_on;
  // slow sink: with stall set, ready only every other cycle, otherwise always ready
  always @(posedge clock)
  begin
    tx_line_ready <= stall ? ~tx_line_ready : 1'b1;
    if (tx_line_valid === 1'b1 && tx_line_ready === 1'b1)
    begin
      tx_got.push_back(tx_line_data);
      last_got.push_back(tx_line_last);
    end
  end
  // data settles before the valid edge, holds past it, then is scrambled
  task automatic send_rx(input logic [7:0] b);
    phy_rx_data <= b;
    repeat (3) @(posedge clock);
    phy_rx_valid <= 1'b1;
    repeat (4) @(posedge clock);
    phy_rx_valid <= 1'b0;
    repeat (3) @(posedge clock);
    phy_rx_data <= ~b;
    repeat (6) @(posedge clock);
  endtask
endmodule

//--- testbench/tb.sv
// self-checking bench for the mac enable and deferral control block
// assumes the phy model at the line side and apb driven from here
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("unexpected t=%0t got %h exp %h", $time, (a), (b)); end end
module tb;
  import mtd_pkg::*;
  localparam int SLOT_CLKS = SLOT_BITS * CLKS_PER_BIT;
  localparam logic [31:0] CTRL_MASK = (32'h1 << CTRL_TRANSMIT_ENABLE_BIT) | (32'h1 << CTRL_RECEIVE_ENABLE_BIT)
    | (32'h1 << CTRL_DEFERRAL_CHECK_ENABLE_BIT) | (32'h3 << CTRL_BACKOFF_LIMIT_LSB);
  typedef struct {logic [31:0] ctrl; logic tx; logic rx;} mtd_row_s;
  logic clock, rst_n, psel, penable, pwrite, pready, pslverr, slverr, ok;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic tx_frame_ready, tx_in_valid, tx_in_last, tx_in_ready, tx_collision, tx_abort;
  logic [7:0] tx_in_data, tx_line_data, phy_rx_data, rx_out_data;
  logic tx_line_valid, tx_line_last, tx_line_ready, phy_crs, phy_rx_valid;
  logic rx_out_valid, rx_out_ready, rx_overrun, crs_on, stall;
  logic [7:0] rxq[$];
  int bad_count, num_checks, abort_n, ovr_n, n, i;
  mtd_row_s rows[8] = '{'{32'h0, 1'b0, 1'b0}, '{32'h8, 1'b1, 1'b0}, '{32'h4, 1'b0, 1'b1},
    '{32'hcc, 1'b1, 1'b1}, '{32'h4c, 1'b1, 1'b1}, '{32'h8c, 1'b1, 1'b1},
    '{32'h2c, 1'b1, 1'b1}, '{32'hffffff13, 1'b0, 1'b0}};
  mtd_mac_ctrl dut (.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .tx_frame_ready, .tx_in_data, .tx_in_valid, .tx_in_last, .tx_in_ready, .tx_collision,
    .tx_line_data, .tx_line_valid, .tx_line_last, .tx_line_ready, .tx_abort, .phy_crs, .phy_rx_data,
    .phy_rx_valid, .rx_out_data, .rx_out_valid, .rx_out_ready, .rx_overrun);
  mtd_phy_model phy (.clock, .crs_on, .stall, .phy_crs, .phy_rx_data, .phy_rx_valid, .tx_line_data,
    .tx_line_valid, .tx_line_last, .tx_line_ready);
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock)
  begin
    if (rx_out_valid === 1'b1 && rx_out_ready === 1'b1) rxq.push_back(rx_out_data);
    if (tx_abort === 1'b1) abort_n++;
    if (rx_overrun === 1'b1) ovr_n++;
  end
  task automatic tally_and_finish();
    if (bad_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // a wait that ran out of cycles ends the run
  task automatic give_up(input logic hit);
    if (hit)
    begin
      bad_count++;
      tally_and_finish();
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clock);
      k++;
    end
    while (pready !== 1'b1 && k < 40);
    r = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 40)
    begin
      bad_count++;
      tally_and_finish();
    end
    @(posedge clock);
  endtask
  // one-byte frame; ok tells whether the byte was taken
  task automatic tx_send(input logic [7:0] b, output logic acc);
    int k;
    tx_frame_ready <= 1'b1;
    tx_in_data <= b;
    tx_in_valid <= 1'b1;
    tx_in_last <= 1'b1;
    acc = 1'b0;
    for (k = 0; k < 60 && !acc; k++)
    begin
      @(posedge clock);
      acc = (tx_in_ready === 1'b1);
    end
    tx_in_valid <= 1'b0;
    tx_frame_ready <= 1'b0;
  endtask
  initial
  begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, tx_collision} = '0;
    {tx_frame_ready, tx_in_valid, tx_in_last, tx_in_data, crs_on, stall} = '0;
    rx_out_ready = 1'b1;
    {bad_count, num_checks, abort_n, ovr_n} = '0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    `CHK(tx_abort, 1'b0)
    apb(1'b0, CTRL_OFFSET, 32'h0, q);
    `CHK(q, CTRL_RESET)
    apb(1'b0, 12'h008, 32'h0, q);
    `CHK(slverr, 1'b1)
    for (i = 0; i < 8; i++)
    begin
      stall <= i[0];
      apb(1'b1, CTRL_OFFSET, rows[i].ctrl, q);
      apb(1'b0, CTRL_OFFSET, 32'h0, q);
      `CHK(q, rows[i].ctrl & CTRL_MASK)
      phy.tx_got.delete();
      phy.last_got.delete();
      tx_send(8'ha0 + i[7:0], ok);
      `CHK(ok, rows[i].tx)
      for (n = 0; n < 30 && phy.tx_got.size() == 0; n++) @(posedge clock);
      `CHK(phy.tx_got.size(), rows[i].tx ? 1 : 0)
      if (rows[i].tx) `CHK(phy.tx_got[0], 8'ha0 + i[7:0])
      if (rows[i].tx) `CHK(phy.last_got[0], 1'b1)
      rxq.delete();
      phy.send_rx(8'h50 + i[7:0]);
      `CHK(rxq.size(), rows[i].rx ? 1 : 0)
      if (rows[i].rx) `CHK(rxq[0], 8'h50 + i[7:0])
    end
    // excessive deferral with the check on, then off
    stall <= 1'b0;
    apb(1'b1, CTRL_OFFSET, 32'h2c, q);
    crs_on <= 1'b1;
    repeat (100) @(posedge clock);
    apb(1'b0, STAT_OFFSET, 32'h0, q);
    `CHK(q[30:16], 15'h0)
    tx_frame_ready <= 1'b1;
    for (n = 0; n < 50000 && tx_abort !== 1'b1; n++) @(posedge clock);
    give_up(n >= 50000);
    `CHK(n >= 2 * DEFER_LIMIT_BITS - 4 && n <= 2 * DEFER_LIMIT_BITS + 12, 1'b1)
    apb(1'b0, STAT_OFFSET, 32'h0, q);
    `CHK(q[STAT_DEFER_ABORT_BIT], 1'b1)
    `CHK(q[30:16] < 15'd40, 1'b1)
    n = abort_n;
    apb(1'b1, CTRL_OFFSET, 32'hc, q);
    repeat (2000) @(posedge clock);
    `CHK(abort_n, n)
    apb(1'b0, STAT_OFFSET, 32'h0, q);
    `CHK(q[30:16] >= 15'd1000 && q[30:16] < 15'd1100, 1'b1)
    `CHK(q[STAT_TX_BUSY_BIT], 1'b1)
    // collision on reaching the sending state before any byte is offered, back-off length in whole slots
    crs_on <= 1'b0;
    for (n = 0; n < 40 && tx_in_ready !== 1'b1; n++) @(posedge clock);
    give_up(n >= 40);
    tx_collision <= 1'b1;
    @(posedge clock);
    tx_collision <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (tx_in_ready !== 1'b1 && n < 17000);
    give_up(n >= 17000);
    `CHK(n <= 15 * SLOT_CLKS + 20, 1'b1)
    `CHK(n % SLOT_CLKS <= 20, 1'b1)
    tx_send(8'h5a, ok);
    `CHK(ok, 1'b1)
    // receive buffer filled until a byte is dropped, then drained
    rx_out_ready <= 1'b0;
    ovr_n = 0;
    rxq.delete();
    for (i = 0; i < 6 && ovr_n == 0; i++) phy.send_rx(8'h30 + i[7:0]);
    `CHK(ovr_n, 1)
    rx_out_ready <= 1'b1;
    repeat (20) @(posedge clock);
    `CHK(rxq.size(), i - 1)
    `CHK(rxq[0], 8'h30)
    tally_and_finish();
  end
endmodule
